// [nfh_pkg.sv]
// Notes on behaviour
// [RULE_01] device holds 131072 pages of 528 individually addressed byte columns
// [RULE_02] columns 512 to 527 of each page are the sixteen-byte spare area
// [RULE_03] whole pages pass through a 528-byte buffer inside the device
// [RULE_04] each erase block groups 32 consecutive pages
// [RULE_05] 4096 erasable 16K blocks; pages read and program, blocks erase
// [RULE_06] host pulses write strobe low with select low; byte taken on rise
// [RULE_07] command latch high: write-strobe rise loads the command register
// [RULE_08] address latch high: write-strobe rise loads the address registers
// [RULE_09] 26-bit address in four cycles: column, low row, upper rows
// [RULE_10] read and program take four address cycles; erase takes three rows
// [RULE_11] one cycle per command; erase is setup, row address, then execute
// [RULE_12] 00h or 01h main read, 50h spare read, 90h identifier read
// [RULE_13] program is 80h then 10h; erase is 60h then D0h
// [RULE_14] while busy only reset FFh and status 70h are accepted
// [RULE_15] 00h starts in the first buffer half, 01h in the second
// [RULE_16] after a second-half access the pointer returns to the first half
// [RULE_17] select high ends a read; ignored during program or erase busy
// [RULE_18] each read-strobe fall drives a byte and advances the column
// [RULE_19] device floats its bus when deselected or outputs disabled
// [RULE_20] write guard low blocks programming and erasing
// [RULE_21] ready/busy low during program, erase, array read; driven always
// [RULE_22] column cycle A0-A7, rows A9-A25, A8 chosen by 00h or 01h
// [RULE_23] host waits for ready before any command but reset or status
package nfh_pkg;
  localparam logic [7:0] CMD_READ0 = 8'h00;
  localparam logic [7:0] CMD_READ1 = 8'h01;
  localparam logic [7:0] CMD_READSP = 8'h50;
  localparam logic [7:0] CMD_READID = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_PROG = 8'h80;
  localparam logic [7:0] CMD_PROGGO = 8'h10;
  localparam logic [7:0] CMD_ERASE = 8'h60;
  localparam logic [7:0] CMD_ERASEGO = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam int PAGE_BYTES = 528;
  localparam int SPARE_START = 512;
  localparam int PAGES_PER_BLOCK = 32;
  localparam int CLK_NS = 40;
  // strobe phase lengths, 50 ns cycle and 25 ns pulse minimum
  localparam int TWP_NS = 25;
  localparam int TWH_NS = 15;
  localparam int TWHR_NS = 60;
  localparam int TWB_NS = 100;
  localparam int TWP_CYC = (TWP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TWH_CYC = (TWH_NS + CLK_NS - 1) / CLK_NS;
  localparam int TWHR_CYC = (TWHR_NS + CLK_NS - 1) / CLK_NS;
  localparam int TWB_CYC = (TWB_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] PHASE_LOW = 4'(TWP_CYC);
  localparam logic [3:0] PHASE_HIGH = 4'(TWH_CYC);
  localparam logic [3:0] PHASE_TURN = 4'(TWHR_CYC);
  localparam logic [3:0] PHASE_BUSY = 4'(TWB_CYC);

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_READ_SPARE = 3'h1,
    OP_READ_ID = 3'h2,
    OP_PROGRAM = 3'h3,
    OP_ERASE = 3'h4,
    OP_STATUS = 3'h5,
    OP_RESET = 3'h6
  } nfh_op_e;

  typedef struct packed {
    nfh_op_e op;
    logic [25:0] addr;
    logic [9:0] count;
  } nfh_req_s;

  typedef struct packed {
    logic chipSelectN;
    logic cmdLatch;
    logic addrLatch;
    logic writeStrobeN;
    logic read_strobe_n;
    logic writeGuardN;
  } nfh_pins_s;
endpackage : nfh_pkg

// [nfh_byte_seq.sv]
`timescale 1ns/100ps
// one strobe cycle: write or read, with timed low and high phases
module nfh_byte_seq
  import nfh_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic start,
  input wire logic isRead,
  output logic strobeN,
  output logic done
);
  import nfh_pkg::*;
  logic [3:0] cnt, next_cnt;
  logic [1:0] phase, next_phase;
  logic next_strobeN, next_done;

  always_comb begin
    next_cnt = cnt;
    next_phase = phase;
    next_strobeN = strobeN;
    next_done = 1'b0;
    unique case (phase)
      2'd0: begin
        if (start) begin
          next_strobeN = 1'b0;
          next_cnt = PHASE_LOW;
          next_phase = 2'd1;
        end
      end
      2'd1: begin
        if (cnt <= 4'h1) begin
          next_strobeN = 1'b1; // see [RULE_06] byte taken on this rise
          next_cnt = PHASE_HIGH;
          next_phase = 2'd2;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      default: begin
        if (cnt <= 4'h1) begin
          next_done = 1'b1;
          next_phase = 2'd0;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt <= 4'h0;
      phase <= 2'd0;
      strobeN <= 1'b1;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      phase <= next_phase;
      strobeN <= next_strobeN;
      done <= next_done;
    end
  end
  logic unusedRead;
  assign unusedRead = isRead;
endmodule : nfh_byte_seq

// [nfh_host.sv]
`timescale 1ns/100ps
module nfh_host
  import nfh_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic reqValid,
  input wire nfh_pkg::nfh_req_s req,
  output logic reqReady,
  input wire logic wrValid,
  input wire logic [7:0] wrData,
  output logic wrReady,
  output logic rdValid,
  output logic [7:0] rdData,
  output logic opDone,
  input wire logic protectN,
  output nfh_pkg::nfh_pins_s pins,
  input wire logic [7:0] ioIn,
  output logic [7:0] ioOut,
  output logic ioOeN,
  input wire logic readyBusyIn
);
  import nfh_pkg::*;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_CMD = 9'h002,
    ST_ADDR = 9'h004,
    ST_TURN = 9'h008,
    ST_DATA_W = 9'h010,
    ST_CMD2 = 9'h020,
    ST_WAITB = 9'h040,
    ST_WAITR = 9'h080,
    ST_DATA_R = 9'h100
  } nfh_state_e;

  nfh_state_e state, next_state;
  nfh_req_s cur, next_cur;
  nfh_pins_s next_pins;
  logic [7:0] next_ioOut;
  logic next_ioOeN;
  logic [2:0] addrIdx, next_addrIdx;
  logic [9:0] left, next_left;
  logic [3:0] wait_, next_wait;
  logic busy, next_busy;
  logic next_reqReady, next_wrReady, next_rdValid, next_opDone;
  logic [7:0] next_rdData;
  logic seqStart, seqDone, seqRead, strobeN;
  logic [7:0] firstCmd;
  logic [2:0] addrFirst;

  nfh_byte_seq u_seq (
    .clock(clock),
    .resetn(resetn),
    .start(seqStart),
    .isRead(seqRead),
    .strobeN(strobeN),
    .done(seqDone)
  );

  // ***************************************************************
  // command selection
  // ***************************************************************
  always_comb begin
    unique case (cur.op)
      OP_READ: firstCmd = cur.addr[8] ? CMD_READ1 : CMD_READ0; // see [RULE_15] [RULE_22]
      OP_READ_SPARE: firstCmd = CMD_READSP; // see [RULE_12]
      OP_READ_ID: firstCmd = CMD_READID;
      OP_PROGRAM: firstCmd = CMD_PROG; // see [RULE_13]
      OP_ERASE: firstCmd = CMD_ERASE;
      OP_STATUS: firstCmd = CMD_STATUS;
      OP_RESET: firstCmd = CMD_RESET;
      default: firstCmd = CMD_RESET;
    endcase
    // erase skips the column cycle; id takes one address byte
    addrFirst = (cur.op == OP_ERASE) ? 3'd1 : 3'd0; // see [RULE_10] [RULE_11]
  end

  // ***************************************************************
  // sequencer
  // ***************************************************************
  always_comb begin
    next_state = state;
    next_cur = cur;
    next_pins = pins;
    next_ioOut = ioOut;
    next_ioOeN = ioOeN;
    next_addrIdx = addrIdx;
    next_left = left;
    next_wait = wait_;
    next_busy = busy;
    next_reqReady = 1'b0;
    next_wrReady = 1'b0;
    next_rdValid = 1'b0;
    next_rdData = rdData;
    next_opDone = 1'b0;
    seqStart = 1'b0;
    seqRead = 1'b0;
    next_pins.writeGuardN = protectN; // see [RULE_20]
    next_pins.writeStrobeN = strobeN;
    next_pins.read_strobe_n = 1'b1;
    unique case (state)
      ST_IDLE: begin
        next_pins.chipSelectN = 1'b1;
        next_pins.cmdLatch = 1'b0;
        next_pins.addrLatch = 1'b0;
        next_ioOeN = 1'b1;
        next_reqReady = !reqValid;
        // only reset and status may go while the device is busy
        if (reqValid && (readyBusyIn || req.op == OP_RESET || req.op == OP_STATUS)) begin // see [RULE_23] [RULE_14]
          next_cur = req;
          next_state = ST_CMD;
          next_pins.chipSelectN = 1'b0;
          next_pins.cmdLatch = 1'b1; // see [RULE_07]
          next_ioOeN = 1'b0;
          seqStart = 1'b1;
        end
      end
      ST_CMD: begin
        next_ioOut = firstCmd;
        if (seqDone) begin
          next_pins.cmdLatch = 1'b0;
          next_addrIdx = addrFirst;
          next_left = cur.count;
          if (cur.op == OP_STATUS || cur.op == OP_RESET) begin
            next_wait = PHASE_TURN;
            next_state = (cur.op == OP_STATUS) ? ST_TURN : ST_WAITB;
          end else begin
            next_pins.addrLatch = 1'b1; // see [RULE_08]
            next_state = ST_ADDR;
            seqStart = 1'b1;
          end
        end
      end
      ST_ADDR: begin
        // column A0-A7, then A9-A16, A17-A24, A25
        unique case (addrIdx)
          3'd0: next_ioOut = cur.addr[7:0]; // see [RULE_09] [RULE_22]
          3'd1: next_ioOut = cur.addr[16:9];
          3'd2: next_ioOut = cur.addr[24:17];
          default: next_ioOut = {7'h00, cur.addr[25]};
        endcase
        if (seqDone) begin
          if (addrIdx == 3'd3 || cur.op == OP_READ_ID) begin
            next_pins.addrLatch = 1'b0;
            next_wait = (cur.op == OP_READ_ID) ? PHASE_TURN : PHASE_BUSY;
            unique case (cur.op)
              OP_PROGRAM: begin
                next_state = ST_DATA_W;
                next_wrReady = 1'b1;
              end
              OP_ERASE: begin
                next_state = ST_CMD2;
                next_pins.cmdLatch = 1'b1;
                seqStart = 1'b1;
              end
              OP_READ_ID: next_state = ST_TURN;
              default: next_state = ST_WAITB;
            endcase
          end else begin
            next_addrIdx = addrIdx + 3'd1;
            seqStart = 1'b1;
          end
        end
      end
      ST_DATA_W: begin
        if (wrValid && wrReady) begin
          next_ioOut = wrData;
          seqStart = 1'b1;
          next_left = left - 10'd1;
        end else if (seqDone) begin
          if (left == 10'd0) begin
            next_pins.cmdLatch = 1'b1;
            next_state = ST_CMD2;
            seqStart = 1'b1;
          end else begin
            next_wrReady = 1'b1;
          end
        end else if (!wrValid && left != 10'd0 && !next_pins.writeStrobeN == 1'b0) begin
          next_wrReady = wrReady;
        end
      end
      ST_CMD2: begin
        next_ioOut = (cur.op == OP_ERASE) ? CMD_ERASEGO : CMD_PROGGO; // see [RULE_13] [RULE_11]
        if (seqDone) begin
          next_pins.cmdLatch = 1'b0;
          next_wait = PHASE_BUSY;
          next_state = ST_WAITB;
        end
      end
      ST_WAITB: begin
        next_ioOeN = 1'b1;
        // busy goes low within tWB; chip select stays low for program/erase
        if (wait_ <= 4'h1) begin
          next_state = ST_WAITR;
        end else begin
          next_wait = wait_ - 4'h1;
        end
      end
      ST_WAITR: begin
        if (readyBusyIn) begin // see [RULE_21]
          if (cur.op == OP_READ || cur.op == OP_READ_SPARE) begin
            next_state = (left == 10'd0) ? ST_IDLE : ST_DATA_R;
            next_opDone = (left == 10'd0);
          end else begin
            next_state = ST_IDLE;
            next_opDone = 1'b1;
          end
        end
      end
      ST_TURN: begin
        next_ioOeN = 1'b1;
        if (wait_ <= 4'h1) begin
          next_state = ST_DATA_R;
          if (cur.op == OP_STATUS) begin
            next_left = 10'd1;
          end
        end else begin
          next_wait = wait_ - 4'h1;
        end
      end
      ST_DATA_R: begin
        next_ioOeN = 1'b1; // see [RULE_19] bus released to the device
        next_pins.read_strobe_n = strobeN;
        if (left == 10'd0) begin
          // raising select ends the read and returns device to standby
          next_state = ST_IDLE;
          next_pins.chipSelectN = 1'b1; // see [RULE_17]
          next_opDone = 1'b1;
        end else if (pins.read_strobe_n && strobeN && !busy) begin
          seqStart = 1'b1;
          seqRead = 1'b1;
          next_busy = 1'b1;
        end else if (seqDone) begin
          next_busy = 1'b0;
          next_left = left - 10'd1;
          next_rdValid = 1'b1;
        end else if (!pins.read_strobe_n) begin
          next_rdData = ioIn; // see [RULE_18] sampled at the end of the low phase
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (state != ST_DATA_R) begin
      next_pins.writeStrobeN = (state == ST_IDLE) ? 1'b1 : strobeN;
    end else begin
      next_pins.writeStrobeN = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      cur <= '0;
      pins <= '{chipSelectN: 1'b1, cmdLatch: 1'b0, addrLatch: 1'b0,
        writeStrobeN: 1'b1, read_strobe_n: 1'b1, writeGuardN: 1'b0};
      ioOut <= 8'h00;
      ioOeN <= 1'b1;
      addrIdx <= 3'd0;
      left <= 10'd0;
      wait_ <= 4'h0;
      busy <= 1'b0;
      reqReady <= 1'b0;
      wrReady <= 1'b0;
      rdValid <= 1'b0;
      rdData <= 8'h00;
      opDone <= 1'b0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      pins <= next_pins;
      ioOut <= next_ioOut;
      ioOeN <= next_ioOeN;
      addrIdx <= next_addrIdx;
      left <= next_left;
      wait_ <= next_wait;
      busy <= next_busy;
      reqReady <= next_reqReady;
      wrReady <= next_wrReady;
      rdValid <= next_rdValid;
      rdData <= next_rdData;
      opDone <= next_opDone;
    end
  end
endmodule : nfh_host

// [nfh_host_properties.sv]
`timescale 1ns/100ps
// ****
// pin checks
// ****
module nfh_host_properties
  import nfh_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic protectN,
  input wire nfh_pkg::nfh_pins_s pins,
  input wire logic [7:0] ioOut,
  input wire logic ioOeN,
  input wire logic readyBusyIn,
  input wire logic opDone
);
  import nfh_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  sequence s_we_fall;
    $fell(pins.writeStrobeN);
  endsequence
  sequence s_we_rise;
    $rose(pins.writeStrobeN);
  endsequence
  a_we_selected: assert property (!pins.writeStrobeN |-> !pins.chipSelectN)
    else $error("write strobe while deselected");
  a_we_width: assert property (s_we_fall |=> s_we_rise)
    else $error("write strobe low too long");
  a_we_drives: assert property (s_we_rise |-> !$past(ioOeN))
    else $error("byte not driven during write");
  a_latch_hold: assert property (
      s_we_rise |-> $stable(ioOut) && $stable(pins.cmdLatch) && $stable(pins.addrLatch))
    else $error("byte or latch moved at strobe rise");
  a_latch_excl: assert property (!(pins.cmdLatch && pins.addrLatch))
    else $error("both latches high");
  a_no_clash: assert property (!pins.read_strobe_n |-> ioOeN && pins.writeStrobeN)
    else $error("host drives during read strobe");
  // the byte is judged while busy was already low one clock before the strobe rise
  a_busy_cmds: assert property (
      s_we_rise and (pins.cmdLatch && !$past(readyBusyIn))
      |-> ioOut inside {CMD_RESET, CMD_STATUS})
    else $error("command issued while busy");
  a_guard_follow: assert property (
      $stable(protectN) [*2] |-> pins.writeGuardN == protectN)
    else $error("write guard not following input");
  a_done_pulse: assert property (opDone |=> !opDone)
    else $error("done held longer than a cycle");
endmodule : nfh_host_properties

// [nfh_flash_model.sv]
`timescale 1ns/100ps
// ****
// device model, one page only
// ****
module nfh_flash_model
  import nfh_pkg::*;
#(
  parameter int BUSY_NS = 1610, // not a whole number of clocks: ready never rises on an edge
  parameter logic [7:0] ID_BYTE = 8'h3C // arbitrary value
)
(
  input wire nfh_pkg::nfh_pins_s pins,
  input wire logic [7:0] busIn,
  input wire logic busOeN,
  output logic [7:0] ioWire,
  output logic pullLow
);
  import nfh_pkg::*;
  logic [7:0] mem [0:PAGE_BYTES-1];
  logic [7:0] pbuf [0:PAGE_BYTES-1];
  logic [7:0] cmd, outByte, dBus, cmdLog [$], addrLog [$];
  logic dCle, dAle, dCs, busy, half;
  int col, addrCnt, lateCmds;
  event kick;
  // lag so a byte changing with the strobe edge is not taken
  assign #1 dBus = busIn;
  assign #1 dCle = pins.cmdLatch;
  assign #1 dAle = pins.addrLatch;
  assign #1 dCs = pins.chipSelectN;
  assign pullLow = busy;
  // released bus shows the inverse of the last byte
  assign ioWire = !busOeN ? busIn : (!pins.chipSelectN && !pins.read_strobe_n) ? outByte
      : ~outByte;
  initial begin
    busy = 0;
    half = 0;
    col = 0;
    lateCmds = 0;
    cmd = 8'h00;
    outByte = 8'h00;
    for (int i = 0; i < PAGE_BYTES; i++) mem[i] = 8'(i * 3);
  end
  always begin
    @(kick);
    busy = 1;
    #(BUSY_NS);
    busy = 0;
  end
  always @(posedge pins.writeStrobeN) begin
    if (!dCs && dCle) begin
      if (busy && !(dBus inside {CMD_RESET, CMD_STATUS})) begin
        lateCmds++;
      end else begin
        cmd = dBus;
        cmdLog.push_back(dBus);
        half = (dBus == CMD_READ1);
        if (dBus == CMD_PROG) foreach (pbuf[i]) pbuf[i] = 8'hFF;
        if (dBus == CMD_PROGGO && pins.writeGuardN) foreach (mem[i]) mem[i] &= pbuf[i];
        // whole block goes, modelled as the one page
        if (dBus == CMD_ERASEGO && pins.writeGuardN) foreach (mem[i]) mem[i] = 8'hFF;
        if (dBus inside {CMD_PROGGO, CMD_ERASEGO}) -> kick;
        else addrCnt = 0;
      end
    end else if (!dCs && dAle) begin
      addrLog.push_back(dBus);
      if (addrCnt == 0 && cmd != CMD_ERASE)
        col = (cmd == CMD_READSP) ? SPARE_START + dBus[3:0] : {half, dBus};
      half = 0;
      addrCnt++;
      if (addrCnt == 4 && cmd inside {CMD_READ0, CMD_READ1, CMD_READSP}) begin
        pbuf = mem;
        -> kick;
      end
    end else if (!dCs && cmd == CMD_PROG) begin
      pbuf[col] = dBus;
      col++;
    end
  end
  always @(negedge pins.read_strobe_n) begin
    if (!pins.chipSelectN) begin
      outByte = (cmd == CMD_STATUS) ? {pins.writeGuardN, !busy, 6'h00}
          : (cmd == CMD_READID) ? ID_BYTE : pbuf[col];
      col++;
    end
  end
endmodule : nfh_flash_model

// [nfh_host_tb_top.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin \
  num_checks++; \
  if ((a) !== (b)) begin \
    miscompares++; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (b)); \
  end \
end
module nfh_host_tb_top;
  import nfh_pkg::*;
  localparam logic [7:0] ID_VAL = 8'h3C; // arbitrary value
  logic clock, resetn, reqValid, reqReady, wrValid, wrReady, rdValid, opDone;
  logic protectN, ioOeN, readyBusyIn, pullLow;
  nfh_req_s req;
  nfh_pins_s pins;
  logic [7:0] wrData, rdData, ioOut, ioWire, rq [$], wq [$];
  int miscompares, num_checks, cycles, wi;
  // ****
  // structure
  // ****
  assign readyBusyIn = !pullLow;
  nfh_host i_dut (.clock(clock), .resetn(resetn), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .wrValid(wrValid), .wrData(wrData), .wrReady(wrReady),
    .rdValid(rdValid), .rdData(rdData), .opDone(opDone), .protectN(protectN), .pins(pins),
    .ioIn(ioWire), .ioOut(ioOut), .ioOeN(ioOeN), .readyBusyIn(readyBusyIn));
  nfh_flash_model #(.ID_BYTE(ID_VAL)) i_flash (.pins(pins), .busIn(ioOut), .busOeN(ioOeN),
    .ioWire(ioWire), .pullLow(pullLow));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // ****
  // tasks
  // ****
  task automatic report_and_stop();
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic feed();
    wrValid = wi < wq.size();
    wrData = wrValid ? wq[wi] : 8'h00;
  endtask : feed
  always @(posedge clock) begin
    cycles++;
    if (wrValid === 1'b1 && wrReady === 1'b1) begin
      #1 wi++;
      feed();
    end
    if (cycles >= 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic run_op(input nfh_op_e op, input logic [25:0] a, input logic [9:0] n);
    rq.delete();
    i_flash.cmdLog.delete();
    i_flash.addrLog.delete();
    req = '{op: op, addr: a, count: n};
    reqValid = 1'b1;
    // request level is held until chip select shows it was taken
    for (int t = 0; t < 2000; t++) begin
      @(posedge clock);
      if (pins.chipSelectN === 1'b0) break;
    end
    #1 reqValid = 1'b0;
    for (int t = 0; t < 2000; t++) begin
      @(posedge clock);
      if (rdValid === 1'b1) rq.push_back(rdData);
      if (opDone === 1'b1) break;
    end
    #1;
    `CHK(reqReady, 1'b1)
  endtask : run_op
  task automatic test_id();
    run_op(OP_READ_ID, 26'h0, 10'h1);
    `CHK(i_flash.cmdLog[0], CMD_READID)
    `CHK(rq[0], ID_VAL)
  endtask : test_id
  task automatic test_reads();
    logic [31:0] alog;
    for (int h = 0; h < 2; h++) begin
      run_op(OP_READ, {17'h12345, 1'(h), 8'h02}, 10'h3);
      `CHK(i_flash.cmdLog[0], h ? CMD_READ1 : CMD_READ0)
      alog = {i_flash.addrLog[0], i_flash.addrLog[1], i_flash.addrLog[2], i_flash.addrLog[3]};
      `CHK(alog, 32'h02452301)
      `CHK(rq.size(), 3)
      for (int k = 0; k < 3; k++) `CHK(rq[k], 8'((h * 256 + 2 + k) * 3))
    end
  endtask : test_reads
  task automatic test_spare();
    run_op(OP_READ_SPARE, 26'h3, 10'h2);
    `CHK(i_flash.cmdLog[0], CMD_READSP)
    `CHK({rq[0], rq[1]}, {8'(515 * 3), 8'(516 * 3)})
  endtask : test_spare
  task automatic test_erase();
    protectN = 1'b0;
    run_op(OP_ERASE, 26'h0004200, 10'h0);
    `CHK(i_flash.mem[1], 8'h03)
    protectN = 1'b1;
    run_op(OP_ERASE, 26'h0004200, 10'h0);
    `CHK({i_flash.cmdLog[0], i_flash.cmdLog[1]}, {CMD_ERASE, CMD_ERASEGO})
    `CHK(i_flash.addrCnt, 3)
    `CHK(i_flash.mem[1], 8'hFF)
  endtask : test_erase
  task automatic test_program();
    wq = '{8'h11, 8'h22, 8'h33};
    wi = 0;
    feed();
    run_op(OP_PROGRAM, 26'h5, 10'h3);
    `CHK({i_flash.cmdLog[0], i_flash.cmdLog[$]}, {CMD_PROG, CMD_PROGGO})
    `CHK(i_flash.addrCnt, 4)
    run_op(OP_READ, 26'h5, 10'h3);
    `CHK({rq[0], rq[1], rq[2]}, 24'h112233)
  endtask : test_program
  task automatic test_busy();
    -> i_flash.kick;
    run_op(OP_STATUS, 26'h0, 10'h1);
    `CHK(rq[0], 8'h80)
    // still busy here: the id read has to wait for ready
    run_op(OP_READ_ID, 26'h0, 10'h1);
    `CHK(i_flash.lateCmds, 0)
    `CHK(rq[0], ID_VAL)
    -> i_flash.kick;
    run_op(OP_RESET, 26'h0, 10'h0);
    `CHK(i_flash.cmdLog[0], CMD_RESET)
    `CHK(i_flash.busy, 1'b0)
    `CHK(i_flash.lateCmds, 0)
  endtask : test_busy
  initial begin
    resetn = 1'b0;
    reqValid = 1'b0;
    req = '0;
    wrValid = 1'b0;
    wrData = 8'h00;
    protectN = 1'b1;
    wi = 0;
    cycles = 0;
    miscompares = 0;
    num_checks = 0;
    repeat (12) @(posedge clock);
    #1 resetn = 1'b1;
    test_id();
    test_reads();
    test_spare();
    test_erase();
    test_program();
    test_busy();
    report_and_stop();
  end
endmodule : nfh_host_tb_top
bind nfh_host nfh_host_properties i_props (.clock(clock), .resetn(resetn),
  .protectN(protectN), .pins(pins), .ioOut(ioOut), .ioOeN(ioOeN),
  .readyBusyIn(readyBusyIn), .opDone(opDone));
